/* rtl/sps_pkg.sv */
// Purpose: constants for the stream port status and tx header registers
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes: printed offsets are register indices; byte address is index * 4
package sps_pkg;
    localparam int ADDR_W = 12;
    localparam int REG_W = 16;
    localparam int DATA_W = 32;

    // register indices, byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h0_032;
    localparam logic [ADDR_W-1:0] IDX_HDR_ONE = 12'h0_034;
    localparam logic [ADDR_W-1:0] IDX_HDR_TWO = 12'h0_036;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h0_040;
    localparam logic [ADDR_W-1:0] IDX_SHIFT = 12'h0_002;

    // status layout for channel A; channel B sits CH_B_SHIFT bits higher
    localparam int ST_COPY = 7;
    localparam int ST_MISM = 6;
    localparam int ST_SYNC = 5;
    localparam int ST_FULL = 4;
    localparam int ST_EMPTY = 3;
    localparam int ST_LEN = 2;
    localparam int CH_B_SHIFT = 8;
    localparam logic [REG_W-1:0] ST_RESET = 16'h0_808;
    localparam logic [REG_W-1:0] ST_STICKY = 16'he_4e4;
    localparam logic [REG_W-1:0] ST_LIVE = 16'h1_818;

    // first header register fields
    localparam int H1_SRC_LSB = 10;
    localparam int H1_DBS_LSB = 2;
    localparam int H1_FN_LSB = 0;
    // second header register fields
    localparam int H2_FMT_LSB = 10;
    localparam int H2_TSF = 9;
    localparam int H2_CH_LSB = 3;
    localparam int H2_SPD_LSB = 1;
    localparam logic [REG_W-1:0] H2_WMASK = 16'hf_ffe;
    localparam logic [REG_W-1:0] HDR_RESET = 16'h0_000;

    localparam logic [7:0] SYNC_BYTE = 8'h47;
    localparam logic [5:0] FMT_TS = 6'h20;
    localparam logic [5:0] FMT_SAT = 6'h21;
    localparam logic [7:0] DBS_TS = 8'h06;
    localparam logic [7:0] DBS_SAT = 8'h09;
    localparam logic [1:0] FN_TS = 2'h3;
    localparam logic [1:0] FN_SAT = 2'h2;
    localparam logic [1:0] SPD_LOW = 2'h0;
    localparam logic [1:0] SPD_MID = 2'h1;
    localparam logic [1:0] SPD_HIGH = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/sps_top.sv */
// Purpose: status register and channel A tx header registers of the
//          stream port bridges, reached over AXI4-Lite
// Assumes: event inputs are one-cycle strobes synchronous to clk_i
// Notes: reading the status word clears its sticky flags
//
// Summary of operation
// - channel B copy-info-change flag in bit 15; a status read clears it.
// - set channel B stream-ID mismatch flag bit 14; status read clears.
// - flag bad sync byte (not 47h) in bit 13; status read clears.
// - show live port FIFO full, bit 12 for B, bit 4 for A.
// - show live port FIFO empty, bits 11 and 3; both one after reset.
// - discard tx data of wrong length; set bit 10 or 2; read clears.
// - channel A copy change bit 7, mismatch bit 6, bad sync bit 5.
// - source-ID field bits 15..10 of header one goes into tx header.
// - block-size field bits 9..2 into tx header; software writes 6 or 9.
// - fraction field bits 1..0 into tx header; software writes 11 or 10.
// - format code bits 15..10 of header two; 100000 or 100001.
// - time-shift flag bit 9 of header two copied into tx header.
// - channel number bits 8..3 of header two used for transmit.
// - speed bits 2..1: 00 lowest, 01 middle, 10 highest rate.
// - bit 0 of header two reads zero; software writes zero.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module sps_top #(
    parameter int TS_LEN = 188,
    parameter int SAT_LEN = 130
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AXI4-Lite slave
    input wire logic [sps_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [sps_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [sps_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [sps_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // channel A stream port side
    input wire logic class_valid_a_i,
    input wire logic [5:0] stream_class_id_a_i,
    input wire logic [1:0] copy_generation_info_a_i,
    input wire logic [5:0] stream_class_select_a_i,
    input wire logic sync_valid_a_i,
    input wire logic [7:0] sync_byte_a_i,
    input wire logic port_fifo_full_a_i,
    input wire logic port_fifo_empty_a_i,
    input wire logic tx_len_valid_a_i,
    input wire logic [7:0] tx_len_a_i,
    // channel B stream port side
    input wire logic class_valid_b_i,
    input wire logic [5:0] stream_class_id_b_i,
    input wire logic [1:0] copy_generation_info_b_i,
    input wire logic [5:0] stream_class_select_b_i,
    input wire logic sync_valid_b_i,
    input wire logic [7:0] sync_byte_b_i,
    input wire logic port_fifo_full_b_i,
    input wire logic port_fifo_empty_b_i,
    input wire logic tx_len_valid_b_i,
    input wire logic [7:0] tx_len_b_i,
    input wire logic [5:0] tx_format_b_i,
    // outputs
    output logic tx_discard_a_o,
    output logic tx_discard_b_o,
    output logic [5:0] source_node_field_a_o,
    output logic [7:0] block_size_field_a_o,
    output logic [1:0] fraction_field_a_o,
    output logic [5:0] format_code_field_a_o,
    output logic timeshift_flag_a_o,
    output logic [5:0] tx_channel_a_o,
    output logic [1:0] tx_speed_a_o,
    output logic irq_o
);
    import sps_pkg::*;

    localparam logic [7:0] TS_LEN_B = 8'(TS_LEN);
    localparam logic [7:0] SAT_LEN_B = 8'(SAT_LEN);

    function automatic logic [ADDR_W-1:0] byte_addr(
        input logic [ADDR_W-1:0] idx);
        byte_addr = ADDR_W'(idx << IDX_SHIFT);
    endfunction

    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
        input logic [DATA_W-1:0] wd, input logic [3:0] strb);
        merge = {strb[1] ? wd[15:8] : old[15:8],
                 strb[0] ? wd[7:0] : old[7:0]};
    endfunction

    // expected tx length follows the selected format code
    function automatic logic len_bad(input logic [5:0] fmt,
        input logic [7:0] len);
        len_bad = (fmt == FMT_SAT) ? (len != SAT_LEN_B) : (len != TS_LEN_B);
    endfunction

    logic [REG_W-1:0] status;
    logic [REG_W-1:0] hdr_one;
    logic [REG_W-1:0] hdr_two;
    logic [REG_W-1:0] irq_mask;
    logic [REG_W-1:0] next_status;
    logic [REG_W-1:0] ev_set;
    logic [REG_W-1:0] rd_clr;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic rd_fire;
    logic rd_status;

    // per-channel view, index 0 is A, index 1 is B
    logic cls_v [2];
    logic [5:0] cls_id [2];
    logic [1:0] cgi [2];
    logic [5:0] cls_sel [2];
    logic syn_v [2];
    logic [7:0] syn_b [2];
    logic len_v [2];
    logic [7:0] len [2];
    logic [5:0] fmt [2];
    logic [5:0] last_id [2];
    logic [1:0] last_cgi [2];
    logic seen [2];
    logic [3:0] ev [2];

    assign cls_v = '{class_valid_a_i, class_valid_b_i};
    assign cls_id = '{stream_class_id_a_i, stream_class_id_b_i};
    assign cgi = '{copy_generation_info_a_i, copy_generation_info_b_i};
    assign cls_sel = '{stream_class_select_a_i, stream_class_select_b_i};
    assign syn_v = '{sync_valid_a_i, sync_valid_b_i};
    assign syn_b = '{sync_byte_a_i, sync_byte_b_i};
    assign len_v = '{tx_len_valid_a_i, tx_len_valid_b_i};
    assign len = '{tx_len_a_i, tx_len_b_i};
    assign fmt = '{hdr_two[H2_FMT_LSB +: 6], tx_format_b_i};

    // event detection; ev bits: 0 copy, 1 mismatch, 2 sync, 3 length
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ev[c] = '0;
            ev[c][0] = cls_v[c] && seen[c] && cls_id[c] == last_id[c]
                       && cgi[c] != last_cgi[c];
            ev[c][1] = cls_v[c] && cls_id[c] != cls_sel[c];
            ev[c][2] = syn_v[c] && syn_b[c] != SYNC_BYTE;
            ev[c][3] = len_v[c] && len_bad(fmt[c], len[c]);
        end
    end

    // copy info is compared only against the last packet of any class, and only when that packet has the same class
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < 2; c++) begin
                last_id[c] <= '0;
                last_cgi[c] <= '0;
                seen[c] <= 1'b0;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (cls_v[c]) begin
                    last_id[c] <= cls_id[c];
                    last_cgi[c] <= cgi[c];
                    seen[c] <= 1'b1;
                end
            end
        end
    end

    always_comb begin
        ev_set = '0;
        for (int c = 0; c < 2; c++) begin
            ev_set[ST_COPY + c*CH_B_SHIFT] = ev[c][0];
            ev_set[ST_MISM + c*CH_B_SHIFT] = ev[c][1];
            ev_set[ST_SYNC + c*CH_B_SHIFT] = ev[c][2];
            ev_set[ST_LEN + c*CH_B_SHIFT] = ev[c][3];
        end
        rd_clr = rd_status ? ST_STICKY : '0;
        // set wins over the read clear
        next_status = ((status & ST_STICKY & ~rd_clr) | ev_set)
                      & ST_STICKY;
        next_status[ST_FULL] = port_fifo_full_a_i;
        next_status[ST_FULL + CH_B_SHIFT] = port_fifo_full_b_i;
        next_status[ST_EMPTY] = port_fifo_empty_a_i;
        next_status[ST_EMPTY + CH_B_SHIFT] = port_fifo_empty_b_i;
    end

    // reserved bits never get set because of the sticky mask and the four live fifo bit assignments
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status <= ST_RESET;
        end else begin
            status <= next_status;
        end
    end

    // bad-length data is dropped before the fifo write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_discard_a_o <= 1'b0;
            tx_discard_b_o <= 1'b0;
        end else begin
            tx_discard_a_o <= ev[0][3];
            tx_discard_b_o <= ev[1][3];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(next_status & ST_STICKY & irq_mask);
        end
    end

    // write channel: address and data taken in either order
    assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_addr <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                case (aw_addr)
                    byte_addr(IDX_STATUS), byte_addr(IDX_HDR_ONE),
                    byte_addr(IDX_HDR_TWO), byte_addr(IDX_IRQ_MASK): begin
                        s_axi_bresp_o <= RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp_o <= RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hdr_one <= HDR_RESET;
            hdr_two <= HDR_RESET;
            irq_mask <= '0;
        end else if (wr_fire) begin
            if (aw_addr == byte_addr(IDX_HDR_ONE)) begin
                hdr_one <= merge(hdr_one, w_data, w_strb);
            end
            if (aw_addr == byte_addr(IDX_HDR_TWO)) begin
                // bit 0 is held at zero whatever software writes
                hdr_two <= merge(hdr_two, w_data, w_strb) & H2_WMASK;
            end
            if (aw_addr == byte_addr(IDX_IRQ_MASK)) begin
                irq_mask <= merge(irq_mask, w_data, w_strb);
            end
        end
    end

    // header fields feed the packetiser through one more register stage, one cycle after the registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            source_node_field_a_o <= '0;
            block_size_field_a_o <= '0;
            fraction_field_a_o <= '0;
            format_code_field_a_o <= '0;
            timeshift_flag_a_o <= 1'b0;
            tx_channel_a_o <= '0;
            tx_speed_a_o <= SPD_LOW;
        end else begin
            source_node_field_a_o <= hdr_one[H1_SRC_LSB +: 6];
            block_size_field_a_o <= hdr_one[H1_DBS_LSB +: 8];
            fraction_field_a_o <= hdr_one[H1_FN_LSB +: 2];
            format_code_field_a_o <= hdr_two[H2_FMT_LSB +: 6];
            timeshift_flag_a_o <= hdr_two[H2_TSF];
            tx_channel_a_o <= hdr_two[H2_CH_LSB +: 6];
            tx_speed_a_o <= hdr_two[H2_SPD_LSB +: 2];
        end
    end

    // read channel: data one cycle after the address is taken
    assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
    assign rd_status = rd_fire && s_axi_araddr_i == byte_addr(IDX_STATUS);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= RESP_OKAY;
                case (s_axi_araddr_i)
                    byte_addr(IDX_STATUS): begin
                        s_axi_rdata_o <= {16'h0_000, status};
                    end
                    byte_addr(IDX_HDR_ONE): begin
                        s_axi_rdata_o <= {16'h0_000, hdr_one};
                    end
                    byte_addr(IDX_HDR_TWO): begin
                        s_axi_rdata_o <= {16'h0_000, hdr_two};
                    end
                    byte_addr(IDX_IRQ_MASK): begin
                        s_axi_rdata_o <= {16'h0_000, irq_mask};
                    end
                    default: begin
                        s_axi_rdata_o <= '0;
                        s_axi_rresp_o <= RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end
    end

    sequence seq_rd_status;
        rd_status;
    endsequence

    AST_READ_CLEARS: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        seq_rd_status ##0 (ev_set == '0) |=> ((status & ST_STICKY) == '0))
        else $error("sticky flag survived a status read");
    // every status read leaves exactly the events of its own cycle set
    AST_SET_WINS: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        seq_rd_status |=> ((status & ST_STICKY) == $past(ev_set)))
        else $error("event lost during status read");
    AST_MISMATCH_B: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        class_valid_b_i && stream_class_id_b_i != stream_class_select_b_i
        |=> status[ST_MISM + CH_B_SHIFT])
        else $error("channel B mismatch not flagged");
    AST_SYNC_A: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sync_valid_a_i && sync_byte_a_i != SYNC_BYTE
        |=> status[ST_SYNC] ##1 (status[ST_SYNC] || $past(rd_status)))
        else $error("bad sync byte not flagged");
    AST_FULL_LIVE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 status[ST_FULL + CH_B_SHIFT] == $past(port_fifo_full_b_i))
        else $error("fifo full bit does not follow port");
    AST_EMPTY_LIVE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 status[ST_EMPTY] == $past(port_fifo_empty_a_i))
        else $error("fifo empty bit does not follow port");
    AST_LEN_DISCARD: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        tx_len_valid_a_i && len_bad(hdr_two[H2_FMT_LSB +: 6], tx_len_a_i)
        |=> tx_discard_a_o && status[ST_LEN])
        else $error("bad length not discarded");
    AST_RSVD_ZERO: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        status[9:8] == 2'h0 && status[1:0] == 2'h0 && !hdr_two[0])
        else $error("reserved bit set");
    AST_HDR_PATH: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_fire && aw_addr == byte_addr(IDX_HDR_TWO) && w_strb[1]
        |=> ##1 timeshift_flag_a_o == $past(w_data[H2_TSF], 2))
        else $error("time-shift flag not carried to header");
    AST_SPEED: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 tx_speed_a_o == $past(hdr_two[H2_SPD_LSB +: 2]))
        else $error("speed code not carried");
endmodule // sps_top

/* verification/sps_far_model.sv */
// Purpose: far-side model of the stream port and copy-protect ICs
// Assumes: index 0 is channel A, 1 is channel B; one strobe per call
// Notes: data buses show the inverse of the last value between strobes,
//        so a design that samples outside a strobe sees junk
`timescale 1ns/1ps
module sps_far_model
    import sps_pkg::*;
(
    input wire logic clk_i,
    output logic [1:0] cls_vld_o,
    output logic [1:0][5:0] cls_id_o,
    output logic [1:0][1:0] cg_o,
    output logic [1:0][5:0] sel_o,
    output logic [1:0] sync_vld_o,
    output logic [1:0][7:0] sync_o,
    output logic [1:0] full_o,
    output logic [1:0] empty_o,
    output logic [1:0] len_vld_o,
    output logic [1:0][7:0] len_o,
    output logic [5:0] fmt_b_o
);
    initial begin
        cls_vld_o = '0;
        cls_id_o = '0;
        cg_o = '0;
        sel_o = {6'h05, 6'h05};
        sync_vld_o = '0;
        sync_o = '0;
        full_o = 2'b00;
        empty_o = 2'b11;
        len_vld_o = '0;
        len_o = '0;
        fmt_b_o = FMT_SAT;
    end

    task cls(input int ch, input logic [5:0] id, input logic [1:0] cg);
        @(posedge clk_i);
        cls_vld_o[ch] <= 1'b1;
        cls_id_o[ch] <= id;
        cg_o[ch] <= cg;
        @(posedge clk_i);
        cls_vld_o[ch] <= 1'b0;
        cls_id_o[ch] <= ~id;
        cg_o[ch] <= ~cg;
    endtask

    task syn(input int ch, input logic [7:0] b);
        @(posedge clk_i);
        sync_vld_o[ch] <= 1'b1;
        sync_o[ch] <= b;
        @(posedge clk_i);
        sync_vld_o[ch] <= 1'b0;
        sync_o[ch] <= ~b;
    endtask

    task txl(input int ch, input logic [7:0] n);
        @(posedge clk_i);
        len_vld_o[ch] <= 1'b1;
        len_o[ch] <= n;
        @(posedge clk_i);
        len_vld_o[ch] <= 1'b0;
        len_o[ch] <= ~n;
    endtask

    task lvl(input logic [1:0] f, input logic [1:0] e);
        @(posedge clk_i);
        full_o <= f;
        empty_o <= e;
    endtask
endmodule // sps_far_model

/* verification/stream_port_status_and_tx_header_tb.sv */
// Purpose: self-checking bench for the status and tx header registers
// Assumes: AXI4-Lite master tasks, far side driven by sps_far_model
// Notes: seed fixed at 98 so random header values repeat run to run
`timescale 1ns/1ps
module stream_port_status_and_tx_header_tb;
    import sps_pkg::*;
    localparam int TSL = 188;
    localparam int SATL = 130;
    localparam logic [ADDR_W-1:0] A_ST = IDX_STATUS << IDX_SHIFT;
    localparam logic [ADDR_W-1:0] A_H1 = IDX_HDR_ONE << IDX_SHIFT;
    localparam logic [ADDR_W-1:0] A_H2 = IDX_HDR_TWO << IDX_SHIFT;
    localparam logic [ADDR_W-1:0] A_MSK = IDX_IRQ_MASK << IDX_SHIFT;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rdat;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [1:0] cv, sv, full, empty, lv, disc, fn, spd;
    logic [1:0][1:0] cg;
    logic [1:0][5:0] cid, sel;
    logic [5:0] fmtb, src, fmt, chn, src_e, ch_e;
    logic [1:0][7:0] sb, len;
    logic [7:0] dbs, b;
    logic tsf, irq, t;
    logic [15:0] h1, h2;
    int miscompares = 0;
    int checks = 0;
    int rnd;

    always #4 clk_i = ~clk_i;

    sps_far_model sps_far_model_i (.clk_i(clk_i), .cls_vld_o(cv),
        .cls_id_o(cid), .cg_o(cg), .sel_o(sel), .sync_vld_o(sv),
        .sync_o(sb), .full_o(full), .empty_o(empty), .len_vld_o(lv),
        .len_o(len), .fmt_b_o(fmtb));

    sps_top #(.TS_LEN(TSL), .SAT_LEN(SATL)) sps_top_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .class_valid_a_i(cv[0]),
        .stream_class_id_a_i(cid[0]), .copy_generation_info_a_i(cg[0]),
        .stream_class_select_a_i(sel[0]), .sync_valid_a_i(sv[0]),
        .sync_byte_a_i(sb[0]), .port_fifo_full_a_i(full[0]),
        .port_fifo_empty_a_i(empty[0]), .tx_len_valid_a_i(lv[0]),
        .tx_len_a_i(len[0]), .class_valid_b_i(cv[1]),
        .stream_class_id_b_i(cid[1]), .copy_generation_info_b_i(cg[1]),
        .stream_class_select_b_i(sel[1]), .sync_valid_b_i(sv[1]),
        .sync_byte_b_i(sb[1]), .port_fifo_full_b_i(full[1]),
        .port_fifo_empty_b_i(empty[1]), .tx_len_valid_b_i(lv[1]),
        .tx_len_b_i(len[1]), .tx_format_b_i(fmtb),
        .tx_discard_a_o(disc[0]), .tx_discard_b_o(disc[1]),
        .source_node_field_a_o(src), .block_size_field_a_o(dbs),
        .fraction_field_a_o(fn), .format_code_field_a_o(fmt),
        .timeshift_flag_a_o(tsf), .tx_channel_a_o(chn),
        .tx_speed_a_o(spd), .irq_o(irq));

    function automatic logic [31:0] st(input int ch, input int pos);
        return 32'(1) << (pos + ch * CH_B_SHIFT);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task end_sim;
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50)
            miscompares++;
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready === 1'b1)
                arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50)
            miscompares++;
        rdat = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        #300_000;
        miscompares++;
        end_sim();
    end

    initial begin
        rnd = $urandom(98);
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(A_ST);
        chk(rdat, 32'(ST_RESET));
        for (int i = 0; i < 4; i++) begin
            src_e = 6'($urandom);
            ch_e = 6'($urandom);
            t = 1'($urandom);
            h1 = i[0] ? {src_e, DBS_TS, FN_TS} : {src_e, DBS_SAT, FN_SAT};
            h2 = {i[0] ? FMT_TS : FMT_SAT, t, ch_e, 2'(i % 3), 1'b0};
            wr(A_H1, 32'(h1));
            wr(A_H2, 32'(h2));
            rd(A_H1);
            chk(rdat, 32'(h1));
            rd(A_H2);
            chk(rdat, 32'(h2));
            @(posedge clk_i);
            #1;
            chk(32'({src, dbs, fn}), 32'(h1));
            chk(32'({fmt, tsf, chn, spd, 1'b0}), 32'(h2));
        end
        for (int c = 0; c < 2; c++) begin
            b = 8'($urandom);
            if (b == SYNC_BYTE)
                b = 8'h00;
            sps_far_model_i.cls(c, 6'h05, 2'h0);
            sps_far_model_i.cls(c, 6'h05, 2'h1);
            sps_far_model_i.cls(c, 6'h0a, 2'h1);
            sps_far_model_i.syn(c, SYNC_BYTE);
            sps_far_model_i.syn(c, b);
            sps_far_model_i.txl(c, 8'(c ? SATL : TSL));
            // the discard pulse stands for the one cycle after the strobe
            #1;
            chk(32'(disc[c]), 32'h0);
            sps_far_model_i.txl(c, 8'(c ? SATL + 1 : TSL - 1));
            #1;
            chk(32'(disc[c]), 32'h1);
            rd(A_ST);
            chk(rdat, ST_RESET | st(c, ST_COPY) | st(c, ST_MISM)
                | st(c, ST_SYNC) | st(c, ST_LEN));
            rd(A_ST);
            chk(rdat, 32'(ST_RESET));
        end
        sps_far_model_i.lvl(2'b11, 2'b00);
        repeat (2) @(posedge clk_i);
        rd(A_ST);
        chk(rdat, 32'h0000_1010);
        sps_far_model_i.lvl(2'b00, 2'b11);
        repeat (2) @(posedge clk_i);
        wr(A_MSK, st(0, ST_SYNC));
        rd(A_MSK);
        chk(rdat, st(0, ST_SYNC));
        sps_far_model_i.cls(0, 6'h0b, 2'h0);
        @(posedge clk_i);
        #1;
        chk(32'(irq), 32'h0);
        sps_far_model_i.syn(0, 8'h00);
        @(posedge clk_i);
        #1;
        chk(32'(irq), 32'h1);
        rd(A_ST);
        chk(rdat, ST_RESET | st(0, ST_MISM) | st(0, ST_SYNC));
        #1;
        chk(32'(irq), 32'h0);
        // read and event land on the same edge
        fork
            rd(A_ST);
            sps_far_model_i.syn(1, 8'h11);
        join
        rd(A_ST);
        chk(rdat, ST_RESET | st(1, ST_SYNC));
        wr(A_ST, 32'h0000_ffff);
        chk(32'(resp), 32'(RESP_OKAY));
        rd(A_ST);
        chk(rdat, 32'(ST_RESET));
        rd(12'h004);
        chk({rdat[29:0], resp}, 32'(RESP_SLVERR));
        wr(12'h004, 32'h0000_1234);
        chk(32'(resp), 32'(RESP_SLVERR));
        end_sim();
    end
endmodule // stream_port_status_and_tx_header_tb
